/* File: pkg/smx_consts.vh */
// Summary of operation
// - with per-byte ack control, software decides ack or nack per received byte, except the checksum byte a slave receiver checks.
// - host address enable turns on host notify support and host address.
// - idle_select 0, enabled: flag when scl low over (reload+1)*2048 clocks.
// - primary reload value and idle_select are frozen while primary timeout enabled.
// - extended timeout flags cumulative stretch over (ext reload+1)*2048 clocks.
// - extended reload value is frozen while the extended timeout is enabled.
// - idle_select 1, enabled: flag when scl and sda high over (reload+1)*4; at reload 0xfff the 14-bit count wraps and never flags.
// - checksum is crc-8 poly 0x07, zero start, covers address byte too.
// - one checksum byte is appended as final byte of checked transfers.
// - checksum_transfer without reload: checksum after byte_count minus one bytes.
// - slave role alert enable drives alert pin low, enables alert response address.
// - host role alert enable: falling alert edge sets alert flag, irq if enabled.
// - alert disabled: internal alert level is high, pin free for general use.
// - default address enable acknowledges device default address 0x61.
// - host address enable acknowledges host address 0x08.
// - alert enable with host address enable off acknowledges alert response address 0x0c.
// - slave checking checksum nacks mismatch, acks match, flags checksum error.
// - timeout, checksum error and alert flags interrupt only with error irq enable.
`ifndef SMX_CONSTS_VH
`define SMX_CONSTS_VH
`define SMX_LOW_UNIT 2048
`define SMX_IDLE_UNIT 4
`define SMX_CRC_POLY 8'h07
`define SMX_CRC_INIT 8'h00
`define SMX_ADDR_DEFAULT 7'h61
`define SMX_ADDR_HOST 7'h08
`define SMX_ADDR_ALERT 7'h0c
`define SMX_RELOAD_RST 12'h000
`endif

/* File: logic/smx_sync.v */
`timescale 1ns/100ps
// three-stage synchroniser; output moves once stages two and three agree
module smx_sync (
  input wire clk_in,
  input wire rst_b_in,
  input wire d_in,
  input wire rst_val_in,
  output reg q_out
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      q_out <= 1'b1;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_out <= s3_r;
      end
    end
  end
endmodule // smx_sync

/* File: logic/smx_crc8.v */
`timescale 1ns/100ps
`include "smx_consts.vh"
// serial crc-8 over bits msb first
module smx_crc8 (
  input wire clk_in,
  input wire rst_b_in,
  input wire clear_in,
  input wire bit_valid_in,
  input wire bit_in,
  output reg [7:0] crc_out
);
  function [7:0] crc_step;
    input [7:0] c;
    input b;
    begin
      if (c[7] ^ b) begin
        crc_step = {c[6:0], 1'b0} ^ `SMX_CRC_POLY;
      end else begin
        crc_step = {c[6:0], 1'b0};
      end
    end
  endfunction
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      crc_out <= `SMX_CRC_INIT;
    end else if (clear_in) begin
      crc_out <= `SMX_CRC_INIT;
    end else if (bit_valid_in) begin
      crc_out <= crc_step(crc_out, bit_in);
    end
  end
endmodule // smx_crc8

/* File: logic/smx_ext.v */
`timescale 1ns/100ps
`include "smx_consts.vh"
// smbus extension: timeouts, idle detect, checksum, alert, reserved addresses
module smx_ext (
  input wire clk_in,
  input wire rst_b_in,
  input wire scl_in,
  input wire sda_in,
  input wire alert_pin_in,
  input wire per_byte_ack_ctrl_in,
  input wire host_addr_enable_in,
  input wire default_addr_enable_in,
  input wire alert_enable_in,
  input wire checksum_enable_in,
  input wire checksum_transfer_in,
  input wire reload_mode_in,
  input wire [7:0] byte_count_in,
  input wire error_irq_enable_in,
  input wire primary_timeout_enable_in,
  input wire extended_timeout_enable_in,
  input wire idle_select_in,
  input wire [11:0] primary_reload_value_in,
  input wire [11:0] extended_reload_value_in,
  input wire cfg_write_in,
  input wire stretch_in,
  input wire sw_ack_in,
  input wire byte_done_in,
  input wire frame_start_in,
  input wire slave_rx_in,
  input wire clear_timeout_in,
  input wire clear_checksum_error_in,
  input wire clear_alert_in,
  output reg alert_pin_out,
  output reg alert_pin_oe_out,
  output reg alert_level_out,
  output reg addr_match_out,
  output reg ack_out,
  output reg checksum_slot_out,
  output reg [7:0] checksum_out,
  output reg timeout_flag_out,
  output reg checksum_error_flag_out,
  output reg alert_flag_out,
  output reg error_irq_out,
  output reg host_notify_out,
  output reg [11:0] primary_reload_out,
  output reg idle_select_out,
  output reg [11:0] extended_reload_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_ADDR = 3'b010;
  localparam ST_DATA = 3'b100;

  reg rst_s1_r;
  reg rst_r;
  wire rst_b;
  wire scl_s;
  wire sda_s;
  wire alert_s;
  reg scl_d_r;
  reg sda_d_r;
  reg alert_d_r;
  reg [23:0] low_cnt_r;
  reg [23:0] ext_cnt_r;
  reg [13:0] idle_cnt_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] bytes_r;
  wire [7:0] crc;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire alert_fall;
  wire byte_end;
  wire in_slot;
  wire crc_bad;
  wire to_low;
  wire to_ext;
  wire to_idle;

  function [23:0] limit_of;
    input [11:0] reload;
    input [11:0] unit;
    begin
      limit_of = ({12'h000, reload} + 24'h000001) * {12'h000, unit};
    end
  endfunction

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1_r <= 1'b0;
      rst_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_r <= rst_s1_r;
    end
  end
  assign rst_b = rst_r;

  smx_sync u_scl (
    .clk_in(clk_in),
    .rst_b_in(rst_b),
    .d_in(scl_in),
    .rst_val_in(1'b1),
    .q_out(scl_s)
  );
  smx_sync u_sda (
    .clk_in(clk_in),
    .rst_b_in(rst_b),
    .d_in(sda_in),
    .rst_val_in(1'b1),
    .q_out(sda_s)
  );
  smx_sync u_alert (
    .clk_in(clk_in),
    .rst_b_in(rst_b),
    .d_in(alert_pin_in),
    .rst_val_in(1'b1),
    .q_out(alert_s)
  );

  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_cond = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign alert_fall = alert_enable_in & alert_d_r & ~alert_s;
  assign byte_end = (bit_cnt_r == 4'h8) & scl_fall;
  assign in_slot = checksum_enable_in & checksum_transfer_in &
    ~reload_mode_in & (byte_count_in != 8'h00) &
    (bytes_r == byte_count_in - 8'h01);
  assign crc_bad = (crc != `SMX_CRC_INIT);

  smx_crc8 u_crc (
    .clk_in(clk_in),
    .rst_b_in(rst_b),
    .clear_in(start_cond | frame_start_in),
    .bit_valid_in(scl_rise & (bit_cnt_r < 4'h8) & (state_r != ST_IDLE)),
    .bit_in(sda_s),
    .crc_out(crc)
  );

  assign to_low = primary_timeout_enable_in & ~idle_select_out &
    (low_cnt_r >= limit_of(primary_reload_out, `SMX_LOW_UNIT));
  assign to_ext = extended_timeout_enable_in &
    (ext_cnt_r >= limit_of(extended_reload_out, `SMX_LOW_UNIT));
  assign to_idle = primary_timeout_enable_in & idle_select_out &
    ({10'h000, idle_cnt_r} >= limit_of(primary_reload_out, `SMX_IDLE_UNIT));

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (start_cond) state_nxt = ST_ADDR;
      ST_ADDR: if (stop_cond) state_nxt = ST_IDLE;
        else if (byte_end) state_nxt = ST_DATA;
      ST_DATA: if (stop_cond) state_nxt = ST_IDLE;
        else if (start_cond) state_nxt = ST_ADDR;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      alert_d_r <= 1'b1;
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      bytes_r <= 8'h00;
      low_cnt_r <= 24'h000000;
      ext_cnt_r <= 24'h000000;
      idle_cnt_r <= 14'h0000;
      primary_reload_out <= `SMX_RELOAD_RST;
      idle_select_out <= 1'b0;
      extended_reload_out <= `SMX_RELOAD_RST;
      alert_pin_out <= 1'b0;
      alert_pin_oe_out <= 1'b0;
      alert_level_out <= 1'b1;
      addr_match_out <= 1'b0;
      ack_out <= 1'b0;
      checksum_slot_out <= 1'b0;
      checksum_out <= `SMX_CRC_INIT;
      timeout_flag_out <= 1'b0;
      checksum_error_flag_out <= 1'b0;
      alert_flag_out <= 1'b0;
      error_irq_out <= 1'b0;
      host_notify_out <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      alert_d_r <= alert_s;
      state_r <= state_nxt;
      if (cfg_write_in & ~primary_timeout_enable_in) begin
        primary_reload_out <= primary_reload_value_in;
        idle_select_out <= idle_select_in;
      end
      if (cfg_write_in & ~extended_timeout_enable_in) begin
        extended_reload_out <= extended_reload_value_in;
      end
      if (scl_s | ~primary_timeout_enable_in) begin
        low_cnt_r <= 24'h000000;
      end else if (~to_low) begin
        low_cnt_r <= low_cnt_r + 24'h000001;
      end
      if (state_r == ST_IDLE | ~extended_timeout_enable_in) begin
        ext_cnt_r <= 24'h000000;
      end else if (stretch_in & ~scl_s & ~to_ext) begin
        ext_cnt_r <= ext_cnt_r + 24'h000001;
      end
      if (~(scl_s & sda_s) | ~primary_timeout_enable_in) begin
        idle_cnt_r <= 14'h0000;
      end else if (~to_idle) begin
        idle_cnt_r <= idle_cnt_r + 14'h0001;
      end
      if (start_cond | stop_cond) begin
        bit_cnt_r <= 4'h0;
      end else if ((bit_cnt_r == 4'h9) & scl_fall) begin
        // ack clock ends the byte; decisions below came at eighth fall
        bit_cnt_r <= 4'h0;
      end else if (scl_rise & (state_r != ST_IDLE)) begin
        if (bit_cnt_r < 4'h8) begin
          shift_r <= {shift_r[6:0], sda_s};
        end
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (start_cond) begin
        bytes_r <= 8'h00;
      end else if (byte_end & (state_r == ST_DATA)) begin
        bytes_r <= bytes_r + 8'h01;
      end
      if (byte_end & (state_r == ST_ADDR)) begin
        addr_match_out <=
          (default_addr_enable_in & shift_r[7:1] == `SMX_ADDR_DEFAULT) |
          (host_addr_enable_in & shift_r[7:1] == `SMX_ADDR_HOST) |
          (alert_enable_in & ~host_addr_enable_in &
           shift_r[7:1] == `SMX_ADDR_ALERT);
      end else if (stop_cond) begin
        addr_match_out <= 1'b0;
      end
      host_notify_out <= host_addr_enable_in & addr_match_out &
        (state_r == ST_DATA);
      checksum_slot_out <= in_slot & (state_r == ST_DATA);
      if (bit_cnt_r == 4'h0) begin
        checksum_out <= crc;
      end
      if (byte_end & (state_r == ST_DATA) & slave_rx_in & in_slot) begin
        ack_out <= ~crc_bad;
      end else if (byte_end) begin
        ack_out <= per_byte_ack_ctrl_in ? sw_ack_in : 1'b1;
      end else if (byte_done_in) begin
        ack_out <= ack_out;
      end
      if (to_low | to_ext | to_idle) begin
        timeout_flag_out <= 1'b1;
      end else if (clear_timeout_in) begin
        timeout_flag_out <= 1'b0;
      end
      if (byte_end & (state_r == ST_DATA) & slave_rx_in & in_slot &
          crc_bad) begin
        checksum_error_flag_out <= 1'b1;
      end else if (clear_checksum_error_in) begin
        checksum_error_flag_out <= 1'b0;
      end
      if (alert_fall & host_addr_enable_in) begin
        alert_flag_out <= 1'b1;
      end else if (clear_alert_in) begin
        alert_flag_out <= 1'b0;
      end
      alert_pin_oe_out <= alert_enable_in & ~host_addr_enable_in;
      alert_pin_out <= 1'b0;
      alert_level_out <= alert_enable_in ? alert_s : 1'b1;
      error_irq_out <= error_irq_enable_in &
        (timeout_flag_out | checksum_error_flag_out | alert_flag_out);
    end
  end
endmodule // smx_ext

/* File: testbench/smx_bus_model.sv */
`timescale 1ns/100ps
// bus master stand-in; lines idle high by pull-up
module smx_bus_model (
  output logic scl_out,
  output logic sda_out,
  output logic alert_b_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    alert_b_out = 1'b1;
  end
  task start_frame();
    sda_out = 1'b0;
    #100 scl_out = 1'b0;
  endtask
  task send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      #50 sda_out = b[i];
      #50 scl_out = 1'b1;
      #100 scl_out = 1'b0;
    end
  endtask
  task stop_frame();
    #100 sda_out = 1'b0;
    #100 scl_out = 1'b1;
    #100 sda_out = 1'b1;
  endtask
endmodule // smx_bus_model

/* File: testbench/smx_ext_props.sv */
`timescale 1ns/100ps
module smx_ext_props (
  input logic clk_in,
  input logic rst_b_in,
  input logic host_addr_enable_in,
  input logic alert_enable_in,
  input logic error_irq_enable_in,
  input logic primary_timeout_enable_in,
  input logic extended_timeout_enable_in,
  input logic clear_timeout_in,
  input logic clear_checksum_error_in,
  input logic clear_alert_in,
  input logic alert_pin_out,
  input logic alert_pin_oe_out,
  input logic alert_level_out,
  input logic timeout_flag_out,
  input logic checksum_error_flag_out,
  input logic alert_flag_out,
  input logic error_irq_out,
  input logic [11:0] primary_reload_out,
  input logic idle_select_out,
  input logic [11:0] extended_reload_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // six cycles outlast the reset and pin sync
  sequence s_slave_role;
    (alert_enable_in && !host_addr_enable_in)[*6];
  endsequence
  sequence s_alert_off;
    (!alert_enable_in)[*6];
  endsequence
  property p_irq_gate;
    (!error_irq_enable_in)[*2] |-> !error_irq_out;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq ungated");
  property p_to_hold;
    timeout_flag_out && !clear_timeout_in |=> timeout_flag_out;
  endproperty
  a_to_hold: assert property (p_to_hold) else $error("timeout lost");
  property p_crc_hold;
    checksum_error_flag_out && !clear_checksum_error_in
      |=> checksum_error_flag_out;
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("crc flag lost");
  property p_alert_hold;
    alert_flag_out && !clear_alert_in |=> alert_flag_out;
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert lost");
  property p_prim_frozen;
    primary_timeout_enable_in
      |=> $stable(primary_reload_out) && $stable(idle_select_out);
  endproperty
  a_prim_frozen: assert property (p_prim_frozen) else $error("a moved");
  property p_ext_frozen;
    extended_timeout_enable_in |=> $stable(extended_reload_out);
  endproperty
  a_ext_frozen: assert property (p_ext_frozen) else $error("b moved");
  property p_slave_alert;
    s_slave_role |-> alert_pin_oe_out && !alert_pin_out;
  endproperty
  a_slave_alert: assert property (p_slave_alert) else $error("no pull");
  property p_alert_free;
    s_alert_off |-> alert_level_out && !alert_pin_oe_out;
  endproperty
  a_alert_free: assert property (p_alert_free) else $error("pin held");
  property p_alert_cause;
    $rose(alert_flag_out) |-> $past(alert_enable_in && host_addr_enable_in);
  endproperty
  a_alert_cause: assert property (p_alert_cause) else $error("alert");
endmodule // smx_ext_props
bind smx_ext smx_ext_props u_smx_ext_props (.*);

/* File: testbench/smx_ext_test.sv */
`timescale 1ns/100ps
module smx_ext_test;
  logic clk_in = 0, rst_b_in = 0, host_addr_enable_in = 0;
  logic per_byte_ack_ctrl_in = 1, default_addr_enable_in = 0;
  logic alert_enable_in = 0, checksum_enable_in = 1, checksum_transfer_in = 1;
  logic reload_mode_in = 0, error_irq_enable_in = 0, idle_select_in = 0;
  logic primary_timeout_enable_in = 0, extended_timeout_enable_in = 0;
  logic cfg_write_in = 0, stretch_in = 0, sw_ack_in = 1, byte_done_in = 0;
  logic frame_start_in = 0, slave_rx_in = 1, clear_timeout_in = 0;
  logic clear_checksum_error_in = 0, clear_alert_in = 0;
  logic [7:0] byte_count_in = 8'h02;
  logic [11:0] primary_reload_value_in = 0, extended_reload_value_in = 0;
  logic alert_pin_out, alert_pin_oe_out, alert_level_out, addr_match_out;
  logic ack_out, checksum_slot_out, timeout_flag_out, checksum_error_flag_out;
  logic alert_flag_out, error_irq_out, host_notify_out, idle_select_out;
  logic [7:0] checksum_out;
  logic [11:0] primary_reload_out, extended_reload_out;
  logic scl_in, sda_in, alert_b;
  wire alert_pin_in = alert_b & ~(alert_pin_oe_out & ~alert_pin_out);
  int miscompares = 0, compares = 0, cycles = 0;
  smx_bus_model u_smx_bus_model (.scl_out(scl_in), .sda_out(sda_in),
    .alert_b_out(alert_b));
  smx_ext u_smx_ext (.*);
  always #12.5 clk_in = ~clk_in;
  task tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task check(input string what, input logic [11:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict();
    $display("miscompares %0d compares %0d", miscompares, compares);
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  function automatic logic [7:0] crc8(input logic [7:0] c, d);
    for (int i = 7; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task pulse_cfg();
    cfg_write_in = 1;
    tick(1);
    cfg_write_in = 0;
  endtask
  task frame(input logic [6:0] a, input logic [7:0] d, input logic ok, m);
    logic [7:0] c;
    c = crc8(crc8(8'h00, {a, 1'b0}), d);
    frame_start_in = 1;
    clear_checksum_error_in = 1;
    tick(1);
    frame_start_in = 0;
    clear_checksum_error_in = 0;
    u_smx_bus_model.start_frame();
    u_smx_bus_model.send_bits({a, 1'b0}, 8);
    u_smx_bus_model.send_bits(8'hff, 1);
    tick(8);
    check("addr_match", addr_match_out, m);
    check("notify", host_notify_out, host_addr_enable_in & m);
    for (int i = 0; i < 2; i++) begin
      if (i) tick(6);
      if (i) check("pec", checksum_out, c);
      u_smx_bus_model.send_bits(i ? (ok ? c : ~c) : d, 8);
      tick(8);
      if (i && m) check("ack", ack_out, ok);
      check("slot", checksum_slot_out, !i);
      u_smx_bus_model.send_bits(8'hff, 1);
      byte_done_in = 1;
      tick(1);
      byte_done_in = 0;
    end
    tick(8);
    if (m) check("crc_err", checksum_error_flag_out, !ok);
    u_smx_bus_model.stop_frame();
    tick(8);
  endtask
  initial begin
    tick(12);
    rst_b_in = 1;
    tick(3);
    check("alert_level", alert_level_out, 1);
    primary_timeout_enable_in = 1;
    extended_timeout_enable_in = 1;
    primary_reload_value_in = 12'h005;
    extended_reload_value_in = 12'h007;
    pulse_cfg();
    check("reload_a", primary_reload_out, 0);
    check("reload_b", extended_reload_out, 0);
    u_smx_bus_model.scl_out = 0;
    tick(2040);
    check("to_early", timeout_flag_out, 0);
    tick(20);
    check("to_late", timeout_flag_out, 1);
    u_smx_bus_model.scl_out = 1;
    tick(10);
    check("to_sticky", timeout_flag_out, 1);
    primary_timeout_enable_in = 0;
    clear_timeout_in = 1;
    idle_select_in = 1;
    primary_reload_value_in = 12'h001;
    pulse_cfg();
    clear_timeout_in = 0;
    primary_timeout_enable_in = 1;
    tick(3);
    check("idle_sel", idle_select_out, 1);
    check("idle_early", timeout_flag_out, 0);
    tick(15);
    check("idle_late", timeout_flag_out, 1);
    primary_timeout_enable_in = 0;
    tick(1);
    for (int k = 0; k < 4; k++) begin
      default_addr_enable_in = (k == 0);
      host_addr_enable_in = (k == 1);
      alert_enable_in = (k == 2);
      frame(k == 1 ? 7'h08 : k == 2 ? 7'h0c : 7'h61, 8'(8'h5a + k), k[0],
        k < 3);
    end
    alert_enable_in = 1;
    tick(8);
    check("alert_oe", alert_pin_oe_out, 1);
    check("alert_drv", alert_pin_out, 0);
    host_addr_enable_in = 1;
    error_irq_enable_in = 1;
    // older flags would mask the alert interrupt
    clear_timeout_in = 1;
    clear_checksum_error_in = 1;
    tick(8);
    clear_timeout_in = 0;
    clear_checksum_error_in = 0;
    tick(2);
    check("irq_quiet", error_irq_out, 0);
    u_smx_bus_model.alert_b_out = 0;
    tick(10);
    check("alert_flag", alert_flag_out, 1);
    check("irq", error_irq_out, 1);
    u_smx_bus_model.alert_b_out = 1;
    alert_enable_in = 0;
    clear_alert_in = 1;
    tick(1);
    clear_alert_in = 0;
    u_smx_bus_model.alert_b_out = 0;
    tick(10);
    check("alert_lvl", alert_level_out, 1);
    check("alert_off", alert_flag_out, 0);
    give_verdict();
  end
endmodule // smx_ext_test
